// ---- include/cfs_cfg.svh ----
/*
 * Register offsets, field positions, reset values and timing counts
 * of the front-end sampling control. Assumes inclusion by bare name.
 */
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH
`define CFS_ADDR_CTRL 8'h00
`define CFS_ADDR_GAIN 8'h04
`define CFS_ADDR_LOC 8'h36
`define CFS_ADDR_BLANK 8'h37
`define CFS_ADDR_CLAMP 8'h38
`define CFS_ADDR_MSTART 8'h39
`define CFS_ADDR_MEND 8'h3A
`define CFS_ADDR_STAT 8'h3B
`define CFS_MODE_MSB 9
`define CFS_MODE_LSB 8
`define CFS_DCR_BIT 6
`define CFS_CTRL_RST 10'h000
`define CFS_GAIN_RST 2'h1
`define CFS_LOC_RST 12'h800
`define CFS_CLAMP_RST 10'h000
`define CFS_MASK_RST 13'h0000
`define CFS_SHA_SEP 6'h20
`define CFS_STEPS 64
`endif

// ---- include/cfs_cfg_if.sv ----
/*
 * Configuration and status carrier between the register file, the
 * clamp mask and the sampling core. Assumes one clock for all ends.
 */
`timescale 1ns/100ps
interface cfs_cfg_if;
    logic [1:0] mode;
    logic dcr_keep;
    logic [1:0] gain;
    logic [5:0] ref_loc;
    logic [5:0] data_loc;
    logic out_clamp_sel;
    logic [9:0] clamp_level;
    logic [12:0] mask_start;
    logic [12:0] mask_end;
    logic [12:0] line_count;
    logic mask_active;
    logic loc_mismatch;
    modport regs (output mode, dcr_keep, gain, ref_loc, data_loc, out_clamp_sel,
        clamp_level, mask_start, mask_end, input line_count, loc_mismatch);
    modport core (input mode, dcr_keep, gain, ref_loc, data_loc, out_clamp_sel,
        clamp_level, mask_active, output loc_mismatch);
    modport mask (input mask_start, mask_end, output line_count, mask_active);
endinterface

// ---- include/cfs_pkg.sv ----
/*
 * Types of the front-end sampling control.
 * Assumes nothing of its surroundings.
 */
package cfs_pkg;
    typedef enum logic [1:0] {
        CFS_INV = 2'b00,
        CFS_NONINV = 2'b01,
        CFS_SHA = 2'b10,
        CFS_RSVD = 2'b11
    } cfs_mode_e;
    typedef logic [13:0] cfs_word_t;
endpackage

// ---- src/cfs_clamp_mask.sv ----
/*
 * Line counter and black-clamp mask window.
 * Assumes one-cycle frame and line start pulses from the timing generator.
 */
`timescale 1ns/100ps
module cfs_clamp_mask
    import cfs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // timing generator
    input wire logic frame_start,
    input wire logic line_start,
    // configuration
    cfs_cfg_if.mask cfg
);
    logic [12:0] line_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_reg <= 13'h0000;
        end else if (frame_start) begin
            line_reg <= 13'h0000;
        end else if (line_start) begin
            line_reg <= line_reg + 13'h0001;
        end
    end

    assign cfg.line_count = line_reg;
    // window empty when start is past end
    assign cfg.mask_active = (line_reg >= cfg.mask_start) && (line_reg <= cfg.mask_end);
endmodule

// ---- src/cfs_regs.sv ----
/*
 * Register file on a plain strobe port; read data one cycle later.
 * Assumes strobes one cycle long and never both at once.
 */
`timescale 1ns/100ps
`include "cfs_cfg.svh"
module cfs_regs
    import cfs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // configuration
    cfs_cfg_if.regs cfg
);
    logic [9:0] ctrl_reg;
    logic [1:0] gain_reg;
    logic [11:0] loc_reg;
    logic blank_reg;
    logic [9:0] clamp_reg;
    logic [12:0] mstart_reg;
    logic [12:0] mend_reg;
    logic [15:0] rdata_next;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `CFS_CTRL_RST;
            gain_reg <= `CFS_GAIN_RST;
            loc_reg <= `CFS_LOC_RST;
            blank_reg <= 1'b0;
            clamp_reg <= `CFS_CLAMP_RST;
            mstart_reg <= `CFS_MASK_RST;
            mend_reg <= `CFS_MASK_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `CFS_ADDR_CTRL: ctrl_reg <= reg_wdata[9:0];
                `CFS_ADDR_GAIN: gain_reg <= reg_wdata[1:0];
                `CFS_ADDR_LOC: loc_reg <= reg_wdata[11:0];
                `CFS_ADDR_BLANK: blank_reg <= reg_wdata[0];
                `CFS_ADDR_CLAMP: clamp_reg <= reg_wdata[9:0];
                `CFS_ADDR_MSTART: mstart_reg <= reg_wdata[12:0];
                `CFS_ADDR_MEND: mend_reg <= reg_wdata[12:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (reg_addr)
            `CFS_ADDR_CTRL: rdata_next = {6'h00, ctrl_reg};
            `CFS_ADDR_GAIN: rdata_next = {14'h0000, gain_reg};
            `CFS_ADDR_LOC: rdata_next = {4'h0, loc_reg};
            `CFS_ADDR_BLANK: rdata_next = {15'h0000, blank_reg};
            `CFS_ADDR_CLAMP: rdata_next = {6'h00, clamp_reg};
            `CFS_ADDR_MSTART: rdata_next = {3'h0, mstart_reg};
            `CFS_ADDR_MEND: rdata_next = {3'h0, mend_reg};
            `CFS_ADDR_STAT: rdata_next = {2'h0, cfg.loc_mismatch, cfg.line_count};
            default: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rdata_next : 16'h0000;
        end
    end

    assign cfg.mode = ctrl_reg[`CFS_MODE_MSB:`CFS_MODE_LSB];
    assign cfg.dcr_keep = ctrl_reg[`CFS_DCR_BIT];
    assign cfg.gain = gain_reg;
    assign cfg.ref_loc = loc_reg[5:0];
    assign cfg.data_loc = loc_reg[11:6];
    assign cfg.out_clamp_sel = blank_reg;
    assign cfg.clamp_level = clamp_reg;
    assign cfg.mask_start = mstart_reg;
    assign cfg.mask_end = mend_reg;
endmodule

// ---- src/cfs_top.sv ----
/*
 * Digital control of one CCD front-end channel: sampler mode, gain step,
 * sample-edge placement, dc-restore gating, pre-blanking isolation and
 * output substitution, black-clamp masking.
 * Assumes pre-blanking, clamp and line pulses and converter words come
 * from logic on clk; the sensor itself is analog and not modelled.
 */
`timescale 1ns/100ps
`include "cfs_cfg.svh"
module cfs_top
    import cfs_pkg::*;
#(
    parameter int STEPS = `CFS_STEPS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // timing generator
    input wire logic pre_blanking_n,
    input wire logic black_clamp_pulse,
    input wire logic frame_start,
    input wire logic line_start,
    // converter words
    input wire cfs_word_t adc_word,
    input wire logic adc_valid,
    output cfs_word_t out_word,
    output logic out_valid,
    // sampler control
    output logic reference_sample_clock,
    output logic data_level_sample_clock,
    output logic sample_pos,
    output logic sample_neg,
    output logic input_connect,
    output logic input_ground,
    output logic neg_input_ground,
    output logic dcr_switch,
    output logic clamp_gate,
    output logic [1:0] sampler_mode,
    output logic [1:0] gain_code,
    output logic signed [3:0] gain_db,
    output logic pixel_tick
);
    cfs_cfg_if cfg ();

    cfs_regs u_regs (
        .clk(clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .cfg(cfg.regs)
    );

    cfs_clamp_mask u_mask (
        .clk(clk),
        .resetn(resetn),
        .frame_start(frame_start),
        .line_start(line_start),
        .cfg(cfg.mask)
    );

    // fine phase within one pixel period
    logic [5:0] phase_reg;
    logic [5:0] phase_next;
    logic blanking_active;
    logic mode_ok;
    logic ref_hit;
    logic data_hit;
    logic [5:0] data_want;
    cfs_mode_e mode;

    assign mode = cfs_mode_e'(cfg.mode);
    assign blanking_active = ~pre_blanking_n;
    assign mode_ok = (mode != CFS_RSVD);
    assign phase_next = (phase_reg == 6'(STEPS - 1)) ? 6'h00 : phase_reg + 6'h01;
    assign ref_hit = mode_ok && (phase_reg == cfg.ref_loc);
    assign data_hit = (mode == CFS_INV || mode == CFS_NONINV)
        && (phase_reg == cfg.data_loc);
    assign data_want = cfg.ref_loc + `CFS_SHA_SEP;
    assign cfg.loc_mismatch = (mode == CFS_SHA) && (cfg.data_loc != data_want);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= 6'h00;
            pixel_tick <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            pixel_tick <= (phase_reg == 6'(STEPS - 1));
        end
    end

    // sample clocks and sampling strobes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reference_sample_clock <= 1'b0;
            data_level_sample_clock <= 1'b0;
            sample_pos <= 1'b0;
            sample_neg <= 1'b0;
        end else begin
            reference_sample_clock <= ref_hit;
            data_level_sample_clock <= data_hit;
            sample_pos <= ref_hit || data_hit;
            sample_neg <= ref_hit && (mode == CFS_SHA);
        end
    end

    // input switches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_connect <= 1'b0;
            input_ground <= 1'b1;
            neg_input_ground <= 1'b1;
        end else begin
            input_connect <= !blanking_active && mode_ok;
            input_ground <= blanking_active || !mode_ok;
            neg_input_ground <= (mode == CFS_INV);
        end
    end

    // dc restore closes with the reference pulse only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dcr_switch <= 1'b0;
        end else begin
            dcr_switch <= ref_hit && (!blanking_active || cfg.dcr_keep);
        end
    end

    // masked lines drop the clamp pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clamp_gate <= 1'b0;
        end else begin
            clamp_gate <= black_clamp_pulse && !cfg.mask_active;
        end
    end

    // output substitution during pre-blanking
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_word <= 14'h0000;
            out_valid <= 1'b0;
        end else begin
            out_valid <= adc_valid;
            if (blanking_active) begin
                out_word <= cfg.out_clamp_sel ? {4'h0, cfg.clamp_level} : 14'h0000;
            end else begin
                out_word <= adc_word;
            end
        end
    end

    // mode and gain step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sampler_mode <= 2'b00;
            gain_code <= `CFS_GAIN_RST;
            gain_db <= 4'sh0;
        end else begin
            sampler_mode <= cfg.mode;
            gain_code <= cfg.gain;
            unique case (cfg.gain)
                2'b00: gain_db <= -4'sd3;
                2'b01: gain_db <= 4'sd0;
                2'b10: gain_db <= 4'sd3;
                2'b11: gain_db <= 4'sd6;
            endcase
        end
    end

    // cycles since the last reference pulse, restarted when its placement moves
    logic [6:0] ref_gap_reg;
    logic [5:0] ref_loc_seen_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_gap_reg <= 7'h00;
            ref_loc_seen_reg <= 6'h00;
        end else begin
            ref_loc_seen_reg <= cfg.ref_loc;
            if (reference_sample_clock || !mode_ok || (cfg.ref_loc != ref_loc_seen_reg)) begin
                ref_gap_reg <= 7'h00;
            end else if (ref_gap_reg != 7'h7F) begin
                ref_gap_reg <= ref_gap_reg + 7'h01;
            end
        end
    end

    // checks
    inv_ground_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode == CFS_INV) |=> neg_input_ground)
        else $error("inverting mode without grounded minus input");

    blank_isolate_a: assert property (@(posedge clk) disable iff (!resetn)
        blanking_active |=> (input_ground && !input_connect))
        else $error("sampler input not isolated during pre-blanking");

    blank_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        (blanking_active && !cfg.out_clamp_sel) |=> (out_word == 14'h0000))
        else $error("output not zero during pre-blanking");

    blank_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
        (blanking_active && cfg.out_clamp_sel) |=> (out_word == {4'h0, $past(cfg.clamp_level)}))
        else $error("output not clamp level during pre-blanking");

    pass_word_a: assert property (@(posedge clk) disable iff (!resetn)
        !blanking_active |=> (out_word == $past(adc_word)))
        else $error("converter word not passed outside pre-blanking");

    dcr_off_a: assert property (@(posedge clk) disable iff (!resetn)
        (blanking_active && !cfg.dcr_keep) |=> !dcr_switch)
        else $error("dc restore closed during pre-blanking");

    dcr_ref_a: assert property (@(posedge clk) disable iff (!resetn)
        dcr_switch |-> reference_sample_clock)
        else $error("dc restore closed outside reference pulse");

    ref_period_a: assert property (@(posedge clk) disable iff (!resetn)
        ref_gap_reg <= 7'(STEPS))
        else $error("reference pulse not once per pixel");

    mask_drop_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.mask_active |=> !clamp_gate)
        else $error("clamp pulse passed on masked line");

    sha_same_a: assert property (@(posedge clk) disable iff (!resetn)
        ((mode == CFS_SHA) && ref_hit) |=> (sample_pos && sample_neg))
        else $error("differential inputs not sampled together");

    sha_nodata_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode == CFS_SHA) |=> !data_level_sample_clock)
        else $error("data sample clock in sample-and-hold mode");

    rsvd_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode == CFS_RSVD) |=> (!reference_sample_clock && !input_connect))
        else $error("reserved mode is sampling");

    gain_step_a: assert property (@(posedge clk) disable iff (!resetn)
        (cfg.gain == 2'b01) |=> (gain_db == 4'sd0))
        else $error("gain step wrong");

    gain_minus_a: assert property (@(posedge clk) disable iff (!resetn)
        (cfg.gain == 2'b00) |=> (gain_db == -4'sd3))
        else $error("gain step -3 wrong");

    gain_plus3_a: assert property (@(posedge clk) disable iff (!resetn)
        (cfg.gain == 2'b10) |=> (gain_db == 4'sd3))
        else $error("gain step +3 wrong");

    gain_plus6_a: assert property (@(posedge clk) disable iff (!resetn)
        (cfg.gain == 2'b11) |=> (gain_db == 4'sd6))
        else $error("gain step +6 wrong");

    gain_code_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> (gain_code == $past(cfg.gain)))
        else $error("gain code not following register");

    mode_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> (sampler_mode == $past(cfg.mode)))
        else $error("sampler mode not following register");

    ref_single_a: assert property (@(posedge clk) disable iff (!resetn)
        (reference_sample_clock && $stable(cfg.ref_loc)) |=> !reference_sample_clock)
        else $error("reference pulse twice in a row");

    ref_place_a: assert property (@(posedge clk) disable iff (!resetn)
        reference_sample_clock |-> ($past(phase_reg) == $past(cfg.ref_loc)))
        else $error("reference pulse misplaced");

    data_place_a: assert property (@(posedge clk) disable iff (!resetn)
        data_level_sample_clock |-> ($past(phase_reg) == $past(cfg.data_loc)))
        else $error("data pulse misplaced");

    tick_place_a: assert property (@(posedge clk) disable iff (!resetn)
        pixel_tick |-> ($past(phase_reg) == 6'(STEPS - 1)))
        else $error("pixel tick misplaced");

    sha_ref_a: assert property (@(posedge clk) disable iff (!resetn)
        ((mode == CFS_SHA) && ref_hit) |=> reference_sample_clock)
        else $error("sample-and-hold without reference pulse");

    neg_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode != CFS_SHA) |=> !sample_neg)
        else $error("minus input sampled outside sample-and-hold");

    noninv_float_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode != CFS_INV) |=> !neg_input_ground)
        else $error("minus input grounded outside inverting mode");

    run_connect_a: assert property (@(posedge clk) disable iff (!resetn)
        (!blanking_active && mode_ok) |=> (input_connect && !input_ground))
        else $error("sampler input not connected");

    rsvd_ground_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode == CFS_RSVD) |=> input_ground)
        else $error("reserved mode input not grounded");

    rsvd_nodcr_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode == CFS_RSVD) |=> !dcr_switch)
        else $error("dc restore closed in reserved mode");

    dcr_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        (blanking_active && cfg.dcr_keep && ref_hit) |=> dcr_switch)
        else $error("dc restore not kept during pre-blanking");

    dcr_run_a: assert property (@(posedge clk) disable iff (!resetn)
        (!blanking_active && ref_hit) |=> dcr_switch)
        else $error("dc restore open at reference pulse");

    clamp_pass_a: assert property (@(posedge clk) disable iff (!resetn)
        (black_clamp_pulse && !cfg.mask_active) |=> clamp_gate)
        else $error("clamp pulse dropped on open line");

    clamp_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        !black_clamp_pulse |=> !clamp_gate)
        else $error("clamp gate without clamp pulse");

    valid_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> (out_valid == $past(adc_valid)))
        else $error("output valid not following converter");
endmodule

// ---- test/cfs_sensor_model.sv ----
/*
 * Behavioural source of converter words on the sensor side.
 * Assumes one clock shared with the block and an async low reset.
 */
`timescale 1ns/100ps
module cfs_sensor_model
    import cfs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pacing
    input wire logic stall,
    // converter words
    output cfs_word_t adc_word,
    output logic adc_valid
);
    // word moves every cycle so a stuck output cannot pass
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            adc_word <= 14'h0000;
            adc_valid <= 1'b0;
        end else begin
            adc_word <= adc_word + 14'h0123;
            adc_valid <= !stall;
        end
    end
endmodule

// ---- test/cfs_top_test.sv ----
/*
 * Self-checking bench of the front-end sampling control.
 * Assumes the design and the sensor model compiled before it.
 */
`timescale 1ns/100ps
module cfs_top_test;
    import cfs_pkg::*;
    logic clk, resetn, reg_wr, reg_rd, pre_blanking_n, black_clamp_pulse;
    logic frame_start, line_start, adc_valid, stall, out_valid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    cfs_word_t adc_word, out_word, prev_w;
    logic reference_sample_clock, data_level_sample_clock, sample_pos, sample_neg;
    logic input_connect, input_ground, neg_input_ground, dcr_switch, clamp_gate;
    logic pixel_tick, prev_v;
    logic [1:0] sampler_mode, gain_code;
    logic signed [3:0] gain_db;
    int n_errors, compares, cycles, nr, nd, nn, np, nt, rc, dc;

    cfs_top #(.STEPS(64)) DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pre_blanking_n(pre_blanking_n), .black_clamp_pulse(black_clamp_pulse),
        .frame_start(frame_start), .line_start(line_start), .adc_word(adc_word),
        .adc_valid(adc_valid), .out_word(out_word), .out_valid(out_valid),
        .reference_sample_clock(reference_sample_clock),
        .data_level_sample_clock(data_level_sample_clock), .sample_pos(sample_pos),
        .sample_neg(sample_neg), .input_connect(input_connect), .input_ground(input_ground),
        .neg_input_ground(neg_input_ground), .dcr_switch(dcr_switch),
        .clamp_gate(clamp_gate), .sampler_mode(sampler_mode), .gain_code(gain_code),
        .gain_db(gain_db), .pixel_tick(pixel_tick));
    cfs_sensor_model sensor (.clk(clk), .resetn(resetn), .stall(stall),
        .adc_word(adc_word), .adc_valid(adc_valid));

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        compares++;
        if (got != exp) begin
            n_errors++;
            $display("[ERR] t=%0t count got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask
    // one full phase cycle: pulse counts and positions
    task automatic window();
        nr = 0;
        nd = 0;
        nn = 0;
        np = 0;
        nt = 0;
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            #1;
            if (reference_sample_clock === 1'b1) begin
                nr++;
                rc = i;
            end
            if (data_level_sample_clock === 1'b1) begin
                nd++;
                dc = i;
            end
            nn += (sample_neg === 1'b1);
            np += (sample_pos === 1'b1) + 16 * (dcr_switch === 1'b1);
            nt += (pixel_tick === 1'b1);
        end
    endtask

    task automatic t_reset_values();
        rdr(8'h00);
        chk(rd, 16'h0000);
        rdr(8'h04);
        chk(rd, 16'h0001);
        rdr(8'h36);
        chk(rd, 16'h0800);
        rdr(8'h10);
        chk(rd, 16'h0000);
        chk({14'h0000, gain_code}, 16'h0001);
    endtask
    task automatic t_modes();
        int ex_r[4] = '{1, 1, 1, 0};
        int ex_d[4] = '{1, 1, 0, 0};
        int ex_n[4] = '{0, 0, 1, 0};
        int ex_p[4] = '{2 + 16, 2 + 16, 1 + 16, 0};
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, 16'(m) << 8);
            chk({14'h0000, sampler_mode}, 16'(m));
            window();
            chk_n(nr, ex_r[m]);
            chk_n(nd, ex_d[m]);
            chk_n(nn, ex_n[m]);
            chk_n(np, ex_p[m]);
            chk_n(nt, 1);
            if (m < 3)
                chk({15'h0000, neg_input_ground}, 16'(m == 0));
            else
                chk({14'h0000, input_connect, input_ground}, 16'h0001);
        end
        wr(8'h00, 16'h0000);
    endtask
    task automatic t_gain();
        logic [3:0] gdb[4] = '{4'hd, 4'h0, 4'h3, 4'h6};
        for (int g = 3; g >= 0; g--) begin
            wr(8'h04, 16'(g));
            chk({12'h000, gain_db}, {12'h000, gdb[g]});
            chk({14'h0000, gain_code}, 16'(g));
        end
        wr(8'h04, 16'h0001);
    endtask
    task automatic t_location();
        wr(8'h36, 16'h0945);
        window();
        chk_n((dc - rc + 64) % 64, 32);
        // location mismatch is only flagged in sample-and-hold mode
        wr(8'h00, 16'h0200);
        rdr(8'h3B);
        chk({15'h0000, rd[13]}, 16'h0000);
        wr(8'h36, 16'h0905);
        rdr(8'h3B);
        chk({15'h0000, rd[13]}, 16'h0001);
        wr(8'h00, 16'h0000);
        window();
        chk_n((dc - rc + 64) % 64, 31);
        wr(8'h36, 16'h0800);
    endtask
    task automatic t_blanking();
        wr(8'h38, 16'h0155);
        wr(8'h37, 16'h0001);
        wr(8'h00, 16'h0040);
        @(posedge clk);
        pre_blanking_n <= 1'b0;
        window();
        chk_n(np, 2 + 16);
        chk({14'h0000, input_connect, input_ground}, 16'h0001);
        chk({2'b00, out_word}, 16'h0155);
        wr(8'h00, 16'h0000);
        wr(8'h37, 16'h0000);
        window();
        chk_n(np, 2);
        chk({2'b00, out_word}, 16'h0000);
        @(posedge clk);
        pre_blanking_n <= 1'b1;
        stall <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            #1;
            prev_w = adc_word;
            prev_v = adc_valid;
            @(posedge clk);
            stall <= (i < 2);
            #1;
            chk({1'b0, out_valid, out_word}, {1'b0, prev_v, prev_w});
        end
        chk({14'h0000, input_connect, input_ground}, 16'h0002);
    endtask
    task automatic lines(input int n, input logic frame);
        @(posedge clk);
        frame_start <= frame;
        line_start <= !frame;
        @(posedge clk);
        frame_start <= 1'b0;
        line_start <= 1'b0;
        if (n > 1)
            lines(n - 1, 1'b0);
    endtask
    task automatic clamp_at(input logic exp);
        @(posedge clk);
        black_clamp_pulse <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, clamp_gate}, {15'h0000, exp});
        @(posedge clk);
        black_clamp_pulse <= 1'b0;
    endtask
    // clamp pulses only while pre-blanking is idle
    task automatic t_clamp_mask();
        wr(8'h39, 16'h0002);
        wr(8'h3A, 16'h0003);
        lines(1, 1'b1);
        clamp_at(1'b1);
        lines(2, 1'b0);
        rdr(8'h3B);
        chk({3'b000, rd[12:0]}, 16'h0002);
        clamp_at(1'b0);
        lines(2, 1'b0);
        clamp_at(1'b1);
        lines(1, 1'b1);
        rdr(8'h3B);
        chk({3'b000, rd[12:0]}, 16'h0000);
    endtask

    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        pre_blanking_n = 1'b1;
        black_clamp_pulse = 1'b0;
        frame_start = 1'b0;
        line_start = 1'b0;
        stall = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        chk({13'h0000, input_ground, neg_input_ground, reference_sample_clock},
            16'h0006);
        @(posedge clk);
        resetn <= 1'b1;
        t_reset_values();
        t_modes();
        t_gain();
        t_location();
        t_blanking();
        t_clamp_mask();
        final_report();
    end
endmodule
